// ### rtl/bridge_regs_cfg.svh
`ifndef BRIDGE_REGS_CFG_SVH
`define BRIDGE_REGS_CFG_SVH

// configuration byte offsets of the two registers (one shared dword)
`define CMD_OFFSET 8'h04
`define STAT_OFFSET 8'h06

// command field positions
`define CMD_IO_EN_BIT 0
`define CMD_MEM_EN_BIT 1
`define CMD_INIT_EN_BIT 2
`define CMD_SPECIAL_BIT 3
`define CMD_MWI_EN_BIT 4
`define CMD_PALETTE_BIT 5
`define CMD_PERR_EN_BIT 6
`define CMD_STEP_BIT 7
`define CMD_SERR_EN_BIT 8
`define CMD_FBB_BIT 9
`define CMD_INTX_BIT 10

// command bits software may change; every other bit is hardwired zero
`define CMD_RW_MASK 16'h0157
`define CMD_RESET 16'h0000

// status field positions
`define STAT_CAPLIST_BIT 4
`define STAT_INIT_PAR_BIT 8
`define STAT_SIG_TABORT_BIT 11
`define STAT_REC_TABORT_BIT 12
`define STAT_REC_MABORT_BIT 13
`define STAT_SIG_SERR_BIT 14
`define STAT_DET_PERR_BIT 15

// status bits that hardware sets and software clears by writing one
`define STAT_CLR_MASK 16'hF900
`define STAT_RESET 16'h0010

`endif

// ### rtl/bridge_regs_pkg.sv
package bridge_regs_pkg;

  // configuration access arriving from the upstream link
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

  // one-cycle event strobes from the link and bus engines
  typedef struct packed {
    logic poisoned_cpl_rx;
    logic poisoned_wr_rx;
    logic pci_serr_seen;
    logic ur_cpl_rx;
    logic ca_cpl_rx;
    logic ca_signaled;
  } bridge_events_s;

  typedef enum logic {
    REQ_MEM,
    REQ_IO
  } space_e;

  // downstream request offered for decode
  typedef struct packed {
    logic valid;
    space_e space;
    logic is_write;
  } ds_req_s;

  // decode verdict for the downstream request
  typedef struct packed {
    logic forward;
    logic unsupported;
    logic promote_mwi;
  } ds_resp_s;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] stat;
    logic [31:0] rdata;
    logic rvalid;
    logic err_msg;
    logic bad_parity;
  } regs_state_s;

endpackage : bridge_regs_pkg

// ### rtl/bridge_command_status_regs.sv
`timescale 1ns/1ps
// Behaviour
// - command bits 15:11 read zero and ignore writes
// - interrupt disable bit is read-only zero; no internal interrupts exist
// - no fast back-to-back cycles; its enable bit reads zero
// - bus SERR reported upstream as error message only while system error enable set
// - no address/data stepping; its control bit hardwired zero
// - poisoned TLP sets data parity status only with parity response enabled
// - poisoned write forwarded to PCI with bad parity regardless of enables
// - no palette snooping; its enable bit reads zero
// - memory writes promoted to write-and-invalidate only while promote bit set
// - special cycles ignored; their enable bit reads zero
// - initiator enable set allows upstream transactions and secondary forwarding
// - initiator enable clear blocks link initiation and secondary memory/IO claims
// - memory enable clear answers downstream memory requests as unsupported
// - memory enable set forwards downstream memory requests to PCI
// - I/O enable clear answers downstream I/O requests as unsupported
// - I/O enable set forwards downstream I/O requests to PCI
// - 16-bit status register at offset 06h resets to 0010h
// - signaled system error set when error message sent with enable set
// - data parity set on poisoned completion or poisoned write when enabled
`include "bridge_regs_cfg.svh"

module bridge_command_status_regs
  import bridge_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire bridge_events_s events,
  input wire ds_req_s ds_req,
  output ds_resp_s ds_resp,
  input wire logic us_tlp_req,
  output logic us_tlp_go,
  input wire logic sec_cycle_req,
  output logic sec_cycle_claim,
  output logic err_msg_req,
  output logic pci_bad_parity,
  output logic fast_b2b_issue,
  output logic special_cycle_claim,
  output logic stepping_active,
  output logic [15:0] command_bits,
  output logic [15:0] status_bits
);

  regs_state_s st_reg;
  regs_state_s st_next;

  // true when the access addresses the dword that holds both registers
  function automatic logic cfg_hit(input logic [7:0] addr);
    cfg_hit = (addr[7:2] == 6'(`CMD_OFFSET >> 2));
  endfunction : cfg_hit

  // expand two byte enables into a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  logic wr_hit;
  logic rd_hit;
  logic [15:0] cmd_wmask;
  logic [15:0] stat_clr;
  logic [15:0] stat_set;
  logic serr_en;
  logic perr_en;
  logic mem_en;
  logic io_en;
  logic init_en;
  logic mwi_en;

  assign wr_hit = cfg_req.wr && cfg_hit(cfg_req.addr);
  assign rd_hit = cfg_req.rd && cfg_hit(cfg_req.addr);

  // only the writable command bits take write data; the rest stay zero
  assign cmd_wmask = wr_hit ? (lane_mask(cfg_req.be[1:0]) & `CMD_RW_MASK) : 16'h0000;

  // status bits clear on a one written to them
  assign stat_clr = wr_hit ? (lane_mask(cfg_req.be[3:2]) & cfg_req.wdata[31:16]
                              & `STAT_CLR_MASK) : 16'h0000;

  assign serr_en = st_reg.cmd[`CMD_SERR_EN_BIT];
  assign perr_en = st_reg.cmd[`CMD_PERR_EN_BIT];
  assign mem_en = st_reg.cmd[`CMD_MEM_EN_BIT];
  assign io_en = st_reg.cmd[`CMD_IO_EN_BIT];
  assign init_en = st_reg.cmd[`CMD_INIT_EN_BIT];
  assign mwi_en = st_reg.cmd[`CMD_MWI_EN_BIT];

  // hardware set terms for the sticky status bits
  always_comb begin
    stat_set = 16'h0000;
    stat_set[`STAT_DET_PERR_BIT] = events.poisoned_cpl_rx | events.poisoned_wr_rx;
    stat_set[`STAT_SIG_SERR_BIT] = events.pci_serr_seen & serr_en;
    stat_set[`STAT_REC_MABORT_BIT] = events.ur_cpl_rx;
    stat_set[`STAT_REC_TABORT_BIT] = events.ca_cpl_rx;
    stat_set[`STAT_SIG_TABORT_BIT] = events.ca_signaled;
    stat_set[`STAT_INIT_PAR_BIT] = perr_en
                                  & (events.poisoned_cpl_rx | events.poisoned_wr_rx);
  end

  // next state: register updates, read data and event pulses
  always_comb begin
    st_next = st_reg;
    st_next.cmd = ((st_reg.cmd & ~cmd_wmask) | (cfg_req.wdata[15:0] & cmd_wmask))
                  & `CMD_RW_MASK;
    // a set in the same cycle as a clear wins, so no event is lost
    st_next.stat = ((st_reg.stat & ~stat_clr) | stat_set) | `STAT_RESET;
    st_next.rvalid = rd_hit | (cfg_req.rd & ~cfg_hit(cfg_req.addr));
    // unmapped offsets read as zero so software probing sees nothing
    st_next.rdata = rd_hit ? {st_reg.stat, st_reg.cmd} : 32'h0000_0000;
    st_next.err_msg = events.pci_serr_seen & serr_en;
    st_next.bad_parity = events.poisoned_wr_rx;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.cmd <= `CMD_RESET;
      st_reg.stat <= `STAT_RESET;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.rvalid <= 1'b0;
      st_reg.err_msg <= 1'b0;
      st_reg.bad_parity <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_rdata = st_reg.rdata;
  assign cfg_rvalid = st_reg.rvalid;
  assign err_msg_req = st_reg.err_msg;
  assign pci_bad_parity = st_reg.bad_parity;
  assign command_bits = st_reg.cmd;
  assign status_bits = st_reg.stat;

  // hardwired features: the flops behind these bits never hold a one
  assign fast_b2b_issue = st_reg.cmd[`CMD_FBB_BIT];
  assign special_cycle_claim = st_reg.cmd[`CMD_SPECIAL_BIT];
  assign stepping_active = st_reg.cmd[`CMD_STEP_BIT];

  // downstream decode is combinational so the receiver answers in the request cycle
  always_comb begin
    ds_resp = '0;
    if (ds_req.valid) begin
      case (ds_req.space)
        REQ_MEM: begin
          ds_resp.forward = mem_en;
          ds_resp.unsupported = !mem_en;
          ds_resp.promote_mwi = mem_en & ds_req.is_write & mwi_en;
        end
        REQ_IO: begin
          ds_resp.forward = io_en;
          ds_resp.unsupported = !io_en;
        end
        default: begin
          ds_resp.unsupported = 1'b1;
        end
      endcase
    end
  end

  // initiator gating for both directions
  assign us_tlp_go = us_tlp_req & init_en;
  assign sec_cycle_claim = sec_cycle_req & init_en;

  // checks

  AST_CMD_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rvalid && $past(cfg_req.rd) |-> cfg_rdata[15:11] == 5'h00)
    else $error("upper command bits read nonzero");

  AST_INTX_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(wr_hit) && $past(cfg_req.be[1]) |-> !command_bits[`CMD_INTX_BIT])
    else $error("interrupt disable bit took a write");

  AST_FBB_NEVER: assert property (@(posedge core_clk) disable iff (!nrst)
    !fast_b2b_issue && !command_bits[`CMD_FBB_BIT])
    else $error("fast back-to-back enabled");

  AST_ERR_MSG_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
    events.pci_serr_seen && serr_en |=> err_msg_req)
    else $error("bus SERR not reported while enabled");

  AST_ERR_MSG_BLOCK: assert property (@(posedge core_clk) disable iff (!nrst)
    err_msg_req |-> $past(events.pci_serr_seen) && $past(serr_en))
    else $error("error message without enabled SERR");

  AST_STEP_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !stepping_active)
    else $error("stepping bit set");

  AST_INIT_PAR_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(status_bits[`STAT_INIT_PAR_BIT]) |-> $past(perr_en))
    else $error("data parity set with response disabled");

  AST_INIT_PAR_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    perr_en && (events.poisoned_cpl_rx || events.poisoned_wr_rx)
    |=> status_bits[`STAT_INIT_PAR_BIT])
    else $error("data parity not set on poisoned traffic");

  AST_BAD_PARITY: assert property (@(posedge core_clk) disable iff (!nrst)
    events.poisoned_wr_rx |=> pci_bad_parity)
    else $error("poisoned write forwarded with good parity");

  AST_PALETTE_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !command_bits[`CMD_PALETTE_BIT])
    else $error("palette snoop bit set");

  AST_MWI_PROMOTE: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_resp.promote_mwi |-> mwi_en && ds_req.is_write && ds_req.space == REQ_MEM)
    else $error("write promoted without enable");

  AST_SPECIAL_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !special_cycle_claim)
    else $error("special cycle claimed");

  AST_INIT_ALLOW: assert property (@(posedge core_clk) disable iff (!nrst)
    init_en && us_tlp_req && sec_cycle_req |-> us_tlp_go && sec_cycle_claim)
    else $error("initiator enabled but requests blocked");

  AST_INIT_BLOCK: assert property (@(posedge core_clk) disable iff (!nrst)
    !init_en |-> !us_tlp_go && !sec_cycle_claim)
    else $error("initiation while initiator disabled");

  AST_MEM_UR: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.valid && ds_req.space == REQ_MEM && !mem_en
    |-> ds_resp.unsupported && !ds_resp.forward)
    else $error("memory request not refused while disabled");

  AST_MEM_FWD: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.valid && ds_req.space == REQ_MEM && mem_en
    |-> ds_resp.forward && !ds_resp.unsupported)
    else $error("memory request not forwarded while enabled");

  AST_IO_UR: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.valid && ds_req.space == REQ_IO && !io_en
    |-> ds_resp.unsupported && !ds_resp.forward)
    else $error("I/O request not refused while disabled");

  AST_IO_FWD: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.valid && ds_req.space == REQ_IO && io_en
    |-> ds_resp.forward && !ds_resp.unsupported)
    else $error("I/O request not forwarded while enabled");

  AST_STAT_FIXED: assert property (@(posedge core_clk) disable iff (!nrst)
    status_bits[`STAT_CAPLIST_BIT] && (status_bits & 16'h06EF) == 16'h0000)
    else $error("status fixed bits wrong");

  AST_SIG_SERR_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    events.pci_serr_seen && serr_en |=> status_bits[`STAT_SIG_SERR_BIT] && err_msg_req)
    else $error("signaled system error not set with message");

  AST_RW_TAKEN: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit && cfg_req.be[0] ##1 1'b1
    |-> command_bits[7:0] == ($past(cfg_req.wdata[7:0]) & 8'h57))
    else $error("command low byte write not taken as masked");

  // command register: fixed bits stay fixed, writable bits follow their lane

  AST_CMD_UPPER_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(wr_hit) && $past(cfg_req.be[1]) |-> command_bits[15:11] == 5'h00)
    else $error("upper command bits took a write");

  AST_INTX_NEVER: assert property (@(posedge core_clk) disable iff (!nrst)
    !command_bits[`CMD_INTX_BIT])
    else $error("interrupt disable bit set");

  AST_CMD_FIXED: assert property (@(posedge core_clk) disable iff (!nrst)
    (command_bits & ~`CMD_RW_MASK) == 16'h0000)
    else $error("hardwired command bit set");

  AST_CMD_LOW_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !(wr_hit && cfg_req.be[0]) |=> command_bits[7:0] == $past(command_bits[7:0]))
    else $error("command low byte changed without a write");

  AST_SERR_EN_TAKEN: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit && cfg_req.be[1]
    |=> command_bits[`CMD_SERR_EN_BIT] == $past(cfg_req.wdata[`CMD_SERR_EN_BIT]))
    else $error("system error enable write not taken");

  AST_PERR_EN_TAKEN: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit && cfg_req.be[0]
    |=> command_bits[`CMD_PERR_EN_BIT] == $past(cfg_req.wdata[`CMD_PERR_EN_BIT]))
    else $error("parity response enable write not taken");

  // read path: one answer per read, zero outside the register dword

  AST_RVALID_AFTER_RD: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_req.rd |=> cfg_rvalid)
    else $error("read got no valid strobe");

  AST_RVALID_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rvalid |-> $past(cfg_req.rd))
    else $error("valid strobe without a read");

  AST_RDATA_WORD: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_hit |=> cfg_rdata == {$past(status_bits), $past(command_bits)})
    else $error("register read returned wrong word");

  AST_RDATA_UNMAPPED: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_req.rd && !rd_hit |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");

  // status bits: set by events, cleared by a one written to them

  AST_STAT_W1C: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit && cfg_req.be[3] && cfg_req.wdata[31] && !events.poisoned_cpl_rx
    && !events.poisoned_wr_rx |=> !status_bits[`STAT_DET_PERR_BIT])
    else $error("detected parity bit not cleared");

  AST_DET_PERR_ANY: assert property (@(posedge core_clk) disable iff (!nrst)
    events.poisoned_cpl_rx || events.poisoned_wr_rx |=> status_bits[`STAT_DET_PERR_BIT])
    else $error("detected parity bit not set");

  AST_SIG_SERR_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(status_bits[`STAT_SIG_SERR_BIT]) |-> $past(serr_en))
    else $error("signaled system error set while disabled");

  AST_SERR_QUIET: assert property (@(posedge core_clk) disable iff (!nrst)
    !serr_en |=> !err_msg_req)
    else $error("error message while reporting disabled");

  AST_ABORT_BITS_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    events.ur_cpl_rx && events.ca_cpl_rx && events.ca_signaled
    |=> (status_bits & 16'h3800) == 16'h3800)
    else $error("abort status bits not set");

  AST_BAD_PARITY_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    pci_bad_parity |-> $past(events.poisoned_wr_rx))
    else $error("bad parity without a poisoned write");

  // decode and initiator gates

  AST_MWI_WHEN_ENABLED: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.valid && ds_req.space == REQ_MEM && ds_req.is_write && mem_en && mwi_en
    |-> ds_resp.promote_mwi)
    else $error("enabled memory write not promoted");

  AST_IO_NO_PROMOTE: assert property (@(posedge core_clk) disable iff (!nrst)
    ds_req.space == REQ_IO |-> !ds_resp.promote_mwi)
    else $error("I/O request promoted");

  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (!nrst)
    !ds_req.valid |-> !ds_resp.forward && !ds_resp.unsupported && !ds_resp.promote_mwi)
    else $error("decode answered without a request");

  AST_US_GO_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    us_tlp_go |-> us_tlp_req && init_en)
    else $error("upstream start without request and enable");

  AST_SEC_CLAIM_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    sec_cycle_claim |-> sec_cycle_req && init_en)
    else $error("secondary claim without request and enable");

endmodule : bridge_command_status_regs

// ### verification/link_partner.sv
`timescale 1ns/1ps
module link_partner
  import bridge_regs_pkg::*;
(
  input wire logic core_clk,
  output bridge_events_s events,
  output ds_req_s ds_req,
  output logic us_tlp_req,
  output logic sec_cycle_req
);
  // quiet far side until a scenario asks for traffic
  initial begin
    events = '0;
    ds_req = '0;
    us_tlp_req = 1'b0;
    sec_cycle_req = 1'b0;
  end

  // request is held as a level; the decode answers combinationally in the same cycle
  task automatic offer(input logic v, input space_e sp, input logic wr);
    @(posedge core_clk);
    ds_req <= '{valid: v, space: sp, is_write: wr};
    us_tlp_req <= v;
    sec_cycle_req <= v;
    #1;
  endtask : offer

  // event strobes last exactly one cycle, like the real link engines
  task automatic fire(input bridge_events_s e);
    @(posedge core_clk);
    events <= e;
    @(posedge core_clk);
    events <= '0;
    #1;
  endtask : fire
endmodule : link_partner

// ### verification/tb_bridge_command_status_regs.sv
`timescale 1ns/1ps
module tb_bridge_command_status_regs import bridge_regs_pkg::*;;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  cfg_req_s cfg_req = '0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid, us_tlp_go, sec_cycle_claim, err_msg_req, pci_bad_parity;
  logic fast_b2b_issue, special_cycle_claim, stepping_active;
  logic [15:0] command_bits, status_bits;
  bridge_events_s events;
  ds_req_s ds_req;
  ds_resp_s ds_resp;
  logic us_tlp_req, sec_cycle_req;
  int n_mismatch = 0;
  int tests_run = 0;

  bridge_command_status_regs uut (.core_clk(core_clk), .nrst(nrst), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .events(events), .ds_req(ds_req),
    .ds_resp(ds_resp), .us_tlp_req(us_tlp_req), .us_tlp_go(us_tlp_go),
    .sec_cycle_req(sec_cycle_req), .sec_cycle_claim(sec_cycle_claim),
    .err_msg_req(err_msg_req), .pci_bad_parity(pci_bad_parity),
    .fast_b2b_issue(fast_b2b_issue), .special_cycle_claim(special_cycle_claim),
    .stepping_active(stepping_active), .command_bits(command_bits),
    .status_bits(status_bits));

  link_partner far (.core_clk(core_clk), .events(events), .ds_req(ds_req),
    .us_tlp_req(us_tlp_req), .sec_cycle_req(sec_cycle_req));

  // 200 MHz core clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // write strobe lasts one cycle; effect is visible just after the taking edge
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge core_clk);
    cfg_req <= '0;
    #1;
  endtask : cfg_wr

  // read data stands for one cycle only, so it is sampled right after the taking edge
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
    @(posedge core_clk);
    cfg_req <= '0;
    #1;
    chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk("rdata", exp, cfg_rdata);
  endtask : cfg_rd

  task automatic t_reset_values();
    cfg_rd(8'h04, 32'h0010_0000);
    cfg_rd(8'h08, 32'h0000_0000);
    chk("never_on", 32'h0, {29'h0, fast_b2b_issue, special_cycle_claim, stepping_active});
  endtask : t_reset_values

  task automatic t_hardwired();
    cfg_wr(8'h04, 4'h3, 32'h0000_FFFF);
    chk("cmd_all_ones", 32'h0157, {16'h0, command_bits});
    cfg_rd(8'h04, 32'h0010_0157);
    chk("never_on", 32'h0, {29'h0, fast_b2b_issue, special_cycle_claim, stepping_active});
    cfg_wr(8'h08, 4'hF, 32'h0000_0000);
    chk("unmapped_wr", 32'h0157, {16'h0, command_bits});
  endtask : t_hardwired

  // resp packs forward, unsupported, promote from msb down
  task automatic t_decode();
    cfg_wr(8'h04, 4'h3, 32'h0000_0000);
    far.offer(1'b1, REQ_MEM, 1'b1);
    chk("mem_off", 32'h2, {29'h0, ds_resp});
    chk("gates_off", 32'h0, {30'h0, us_tlp_go, sec_cycle_claim});
    far.offer(1'b1, REQ_IO, 1'b0);
    chk("io_off", 32'h2, {29'h0, ds_resp});
    cfg_wr(8'h04, 4'h3, 32'h0000_0007);
    chk("gates_on", 32'h3, {30'h0, us_tlp_go, sec_cycle_claim});
    chk("io_on", 32'h4, {29'h0, ds_resp});
    far.offer(1'b1, REQ_MEM, 1'b1);
    chk("mem_on", 32'h4, {29'h0, ds_resp});
    cfg_wr(8'h04, 4'h1, 32'h0000_0017);
    chk("promote", 32'h5, {29'h0, ds_resp});
    far.offer(1'b1, REQ_MEM, 1'b0);
    chk("read_no_promote", 32'h4, {29'h0, ds_resp});
    far.offer(1'b0, REQ_MEM, 1'b0);
  endtask : t_decode

  task automatic t_events();
    cfg_wr(8'h04, 4'h3, 32'h0000_0000);
    far.fire(6'h10);
    chk("bad_parity", 32'h1, {31'h0, pci_bad_parity});
    chk("stat_perr_off", 32'h8010, {16'h0, status_bits});
    far.fire(6'h08);
    chk("msg_off", 32'h0, {31'h0, err_msg_req});
    chk("stat_serr_off", 32'h8010, {16'h0, status_bits});
    cfg_wr(8'h04, 4'h3, 32'h0000_0140);
    far.fire(6'h20);
    chk("stat_cpl_on", 32'h8110, {16'h0, status_bits});
    far.fire(6'h08);
    chk("msg_on", 32'h1, {31'h0, err_msg_req});
    chk("stat_serr_on", 32'hC110, {16'h0, status_bits});
    cfg_wr(8'h04, 4'hC, 32'hFFFF_0000);
    cfg_rd(8'h04, 32'h0010_0140);
    far.fire(6'h10);
    chk("bad_parity_on", 32'h1, {31'h0, pci_bad_parity});
    chk("stat_wr_on", 32'h8110, {16'h0, status_bits});
  endtask : t_events

  // abort events set their bits; a reset dropped mid-run restores both defaults
  task automatic t_mid_reset();
    cfg_wr(8'h04, 4'h3, 32'h0000_0157);
    far.fire(6'h27);
    chk("stat_aborts", 32'hB910, {16'h0, status_bits});
    @(posedge core_clk);
    nrst <= 1'b0;
    #1;
    chk("cmd_in_reset", 32'h0, {16'h0, command_bits});
    chk("stat_in_reset", 32'h0010, {16'h0, status_bits});
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    cfg_rd(8'h04, 32'h0010_0000);
  endtask : t_mid_reset

  // main sequence: reset held six cycles, then one task per scenario
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_hardwired();
    t_decode();
    t_events();
    t_mid_reset();
    conclude();
  end

  // whole run needs well under 200 cycles; this limit leaves wide margin
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : tb_bridge_command_status_regs
